// File: hdl/return_rotate_pkg.sv
// constants for the return and rotate execution block
// assumes a 14-bit instruction word and 8-bit data path
package return_rotate_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 15;
	localparam int FADDR_W = 7;
	localparam int IRQ_ENABLE_BIT = 7;
	localparam int CARRY_BIT = 0;
	localparam int RETURN_CYCLES = 2;
	localparam int ROTATE_CYCLES = 1;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_RETURN_FROM_INTERRUPT,
		OP_RETURN_SUB,
		OP_RETURN_LOADING_LITERAL,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY
	} op_e;
endpackage : return_rotate_pkg

// File: hdl/rotate_unit.sv
// combinational rotate through carry
// assumes operand and carry already selected by the caller
`timescale 1ns/100ps
`default_nettype none
module rotate_unit #(
	parameter int WIDTH = 8
) (
	input  wire logic             dir_left_in,
	input  wire logic [WIDTH-1:0] value_in,
	input  wire logic             carry_in,
	output logic      [WIDTH-1:0] result_out,
	output logic                  carry_out
);
	wire [WIDTH-1:0] left_w  = {value_in[WIDTH-2:0], carry_in};
	wire [WIDTH-1:0] right_w = {carry_in, value_in[WIDTH-1:1]};
	assign result_out = dir_left_in ? left_w : right_w;
	assign carry_out  = dir_left_in ? value_in[WIDTH-1] : value_in[0];
endmodule : rotate_unit
`default_nettype wire

// File: hdl/return_rotate_exec.sv
// execution of return and rotate-through-carry instructions
// assumes the decoder presents one op with a one-cycle start pulse while not busy
// Functional notes
// - return from interrupt pops the stack and loads the popped top into the program counter.
// - return from interrupt also sets the global interrupt enable at bit 7 of the interrupt control register.
// - return from interrupt is one word, takes two instruction cycles and changes no status flag.
// - return from subroutine pops the stack into the program counter in two cycles with flags untouched.
// - return with literal loads the accumulator with the 8-bit literal and changes no status flag.
// - return with literal also loads the program counter from the popped top in two cycles.
// - rotate left moves old carry into bit 0 and old bit 7 into carry, touching only carry.
// - rotate destination 0 writes the accumulator, destination 1 writes back the file register.
// - rotate right moves old carry into bit 7 and old bit 0 into carry, touching only carry.
`timescale 1ns/100ps
`default_nettype none
module return_rotate_exec #(
	parameter int DATA_W  = return_rotate_pkg::DATA_W,
	parameter int PC_W    = return_rotate_pkg::PC_W,
	parameter int FADDR_W = return_rotate_pkg::FADDR_W
) (
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    start_in,
	input  wire return_rotate_pkg::op_e  op_in,
	input  wire logic [DATA_W-1:0]       literal_in,
	input  wire logic [FADDR_W-1:0]      file_addr_in,
	input  wire logic                    dest_in,
	input  wire logic [DATA_W-1:0]       file_data_in,
	input  wire logic                    carry_in,
	input  wire logic [PC_W-1:0]         stack_top_in,
	output logic                         busy_out,
	output logic                         done_out,
	output logic                         stack_pop_out,
	output logic                         pc_load_out,
	output logic [PC_W-1:0]              pc_out,
	output logic                         acc_we_out,
	output logic [DATA_W-1:0]            acc_out,
	output logic                         file_we_out,
	output logic [FADDR_W-1:0]           file_addr_out,
	output logic [DATA_W-1:0]            file_data_out,
	output logic                         carry_we_out,
	output logic                         carry_out,
	output logic                         irq_enable_set_out,
	output logic [DATA_W-1:0]            irq_enable_mask_out
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SECOND
	} state_e;
	state_e                 state_q;
	state_e                 state_d;
	return_rotate_pkg::op_e op_q;
	logic [DATA_W-1:0]      literal_q;
	logic                   busy_q;
	logic                   done_q;
	logic                   pop_q;
	logic                   pc_load_q;
	logic [PC_W-1:0]        pc_q;
	logic                   acc_we_q;
	logic [DATA_W-1:0]      acc_q;
	logic                   file_we_q;
	logic [FADDR_W-1:0]     file_addr_q;
	logic [DATA_W-1:0]      file_data_q;
	logic                   carry_we_q;
	logic                   carry_q;
	logic                   gie_q;
	logic [DATA_W-1:0]      gie_mask_q;

	wire [DATA_W-1:0] rot_result_w;
	wire              rot_carry_w;
	wire take_w     = start_in && (state_q == ST_IDLE);
	wire is_rot_w   = (op_in == return_rotate_pkg::OP_ROTATE_LEFT_CARRY) ||
	                  (op_in == return_rotate_pkg::OP_ROTATE_RIGHT_CARRY);
	wire is_ret_w   = (op_in == return_rotate_pkg::OP_RETURN_FROM_INTERRUPT) ||
	                  (op_in == return_rotate_pkg::OP_RETURN_SUB) ||
	                  (op_in == return_rotate_pkg::OP_RETURN_LOADING_LITERAL);
	wire rot_go_w   = take_w && is_rot_w;
	wire ret_go_w   = take_w && is_ret_w;
	wire finish_w   = (state_q == ST_SECOND);
	wire to_file_w  = (dest_in == return_rotate_pkg::DEST_FILE);
	wire to_acc_w   = (dest_in == return_rotate_pkg::DEST_ACC);
	wire fin_gie_w  = finish_w && (op_q == return_rotate_pkg::OP_RETURN_FROM_INTERRUPT);
	wire fin_lit_w  = finish_w && (op_q == return_rotate_pkg::OP_RETURN_LOADING_LITERAL);
	wire is_left_w  = (op_in == return_rotate_pkg::OP_ROTATE_LEFT_CARRY);
	wire rot_acc_w  = rot_go_w && to_acc_w;
	wire rot_file_w = rot_go_w && to_file_w;
	wire acc_load_w = rot_acc_w || fin_lit_w;
	wire [DATA_W-1:0] acc_next_w = rot_acc_w ? rot_result_w : literal_q;
	// mask is a constant; registering the select keeps the output a plain flop
	wire [DATA_W-1:0] gie_mask_w = DATA_W'(1) << return_rotate_pkg::IRQ_ENABLE_BIT;

	rotate_unit #(
		.WIDTH(DATA_W)
	) u_rotate (
		.dir_left_in(is_left_w),
		.value_in   (file_data_in),
		.carry_in   (carry_in),
		.result_out (rot_result_w),
		.carry_out  (rot_carry_w)
	);

	// returns take a second cycle: the stack pops and the pc reloads on cycle two
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (ret_go_w) begin
					state_d = ST_SECOND;
				end
			end
			ST_SECOND: begin
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// literal_in may move on after the take edge, so it is held here
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			op_q      <= return_rotate_pkg::OP_NONE;
			literal_q <= return_rotate_pkg::ACC_RESET;
		end else if (ret_go_w) begin
			op_q      <= op_in;
			literal_q <= literal_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			busy_q    <= 1'b0;
			done_q    <= 1'b0;
			pop_q     <= 1'b0;
			pc_load_q <= 1'b0;
		end else begin
			busy_q    <= ret_go_w;
			done_q    <= rot_go_w || finish_w;
			pop_q     <= finish_w;
			pc_load_q <= finish_w;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pc_q <= return_rotate_pkg::PC_RESET;
		end else if (finish_w) begin
			pc_q <= stack_top_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			acc_we_q <= 1'b0;
			acc_q    <= return_rotate_pkg::ACC_RESET;
		end else begin
			acc_we_q <= acc_load_w;
			if (acc_load_w) begin
				acc_q <= acc_next_w;
			end
		end
	end

	// file data follows every rotate; only the write strobe says whether it counts
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			file_we_q   <= 1'b0;
			file_addr_q <= '0;
			file_data_q <= return_rotate_pkg::ACC_RESET;
		end else begin
			file_we_q <= rot_file_w;
			if (rot_go_w) begin
				file_addr_q <= file_addr_in;
				file_data_q <= rot_result_w;
			end
		end
	end

	// only rotates touch a flag; returns never raise carry_we
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			carry_we_q <= 1'b0;
			carry_q    <= 1'b0;
		end else begin
			carry_we_q <= rot_go_w;
			if (rot_go_w) begin
				carry_q <= rot_carry_w;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gie_q      <= 1'b0;
			gie_mask_q <= '0;
		end else begin
			gie_q      <= fin_gie_w;
			gie_mask_q <= fin_gie_w ? gie_mask_w : '0;
		end
	end

	assign busy_out            = busy_q;
	assign done_out            = done_q;
	assign stack_pop_out       = pop_q;
	assign pc_load_out         = pc_load_q;
	assign pc_out              = pc_q;
	assign acc_we_out          = acc_we_q;
	assign acc_out             = acc_q;
	assign file_we_out         = file_we_q;
	assign file_addr_out       = file_addr_q;
	assign file_data_out       = file_data_q;
	assign carry_we_out        = carry_we_q;
	assign carry_out           = carry_q;
	assign irq_enable_set_out  = gie_q;
	assign irq_enable_mask_out = gie_mask_q;
endmodule : return_rotate_exec
`default_nettype wire

// File: sim/return_rotate_exec_checker.sv
// port assertions for the return and rotate block
// assumes one clock domain and bind by port name
`timescale 1ns/100ps
`default_nettype none
module return_rotate_exec_checker (
	input wire logic                   clk_in, rst_n_in, start_in, dest_in, carry_in, busy_out, done_out,
	input wire logic                   stack_pop_out, pc_load_out, acc_we_out, file_we_out, carry_we_out,
	input wire logic                   carry_out, irq_enable_set_out,
	input wire return_rotate_pkg::op_e op_in,
	input wire logic [7:0]             literal_in, file_data_in, acc_out, file_data_out, irq_enable_mask_out,
	input wire logic [14:0]            stack_top_in, pc_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// busy is low on the take edge, so this is the acceptance condition
	wire take = start_in && !busy_out;
	wire rfi = op_in == return_rotate_pkg::OP_RETURN_FROM_INTERRUPT;
	wire lit = op_in == return_rotate_pkg::OP_RETURN_LOADING_LITERAL;
	wire sub = op_in == return_rotate_pkg::OP_RETURN_SUB;
	wire rl = op_in == return_rotate_pkg::OP_ROTATE_LEFT_CARRY;
	wire rr = op_in == return_rotate_pkg::OP_ROTATE_RIGHT_CARRY;
	sequence ret_take; take && (rfi || lit || sub); endsequence
	sequence ret_finish; busy_out && !done_out ##1 done_out && stack_pop_out && pc_load_out; endsequence
	a_ret_two_cycles: assert property (ret_take |-> ##1 ret_finish) else $error("bad return timing");
	a_ret_pc_top: assert property (ret_take |-> ##2 pc_out == $past(stack_top_in)) else $error("bad pc");
	a_ret_keeps_carry: assert property (ret_take |-> ##1 !carry_we_out [*2]) else $error("carry hit");
	a_rti_irq_set: assert property (take && rfi |-> ##2 irq_enable_set_out && irq_enable_mask_out == 8'h80)
		else $error("irq enable not set");
	a_lit_acc_load: assert property (take && lit |-> ##2 acc_we_out && acc_out == $past(literal_in, 2))
		else $error("bad literal");
	a_sub_no_side: assert property (take && sub |-> ##2 !acc_we_out && !irq_enable_set_out)
		else $error("return side effect");
	a_rl_to_acc: assert property (take && rl && !dest_in |-> ##1 acc_we_out && !file_we_out && carry_we_out
		&& {carry_out, acc_out} == {$past(file_data_in), $past(carry_in)}) else $error("bad left rotate");
	a_rr_to_file: assert property (take && rr && dest_in |-> ##1 file_we_out && !acc_we_out
		&& {file_data_out, carry_out} == {$past(carry_in), $past(file_data_in)}) else $error("bad right rotate");
endmodule : return_rotate_exec_checker
bind return_rotate_exec return_rotate_exec_checker checker_inst (.*);
`default_nettype wire

// File: sim/tb.sv
// bench for the return and rotate block
// assumes the block idles after reset; bench plays decoder and stack
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic                   clk_in = 0, rst_n_in = 0, start_in = 0, dest_in = 0, carry_in = 0;
	return_rotate_pkg::op_e op_in = return_rotate_pkg::OP_NONE;
	logic [7:0]             literal_in = 8'h00, file_data_in = 8'h00, acc_out, file_data_out, irq_enable_mask_out;
	logic [6:0]             file_addr_in = 7'h7F, file_addr_out;
	logic [14:0]            stack_top_in = 15'h0000, pc_out;
	logic                   busy_out, done_out, stack_pop_out, pc_load_out, acc_we_out, file_we_out;
	logic                   carry_we_out, carry_out, irq_enable_set_out;
	int                     failures = 0, n_compared = 0, cycles = 0;
	return_rotate_exec DUT (.*);
	always #2 clk_in = ~clk_in;
	// well above the few dozen cycles the tests need
	always @(posedge clk_in) if (++cycles == 2000) begin
		failures++;
		final_report();
	end
	task chk(input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task final_report;
		$display("failures %0d compared %0d", failures, n_compared);
		if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// back-to-back rotates, both directions and both destinations
	task t_rotate;
		logic [8:0] e;
		logic       pd;
		for (int i = 0; i <= 4; i++) begin
			@(posedge clk_in);
			#1;
			if (i > 0) begin
				chk({done_out, carry_we_out}, 2'b11);
				chk({carry_out, pd ? file_data_out : acc_out}, e);
				chk({acc_we_out, file_we_out}, pd ? 2'b01 : 2'b10);
				if (pd) chk(file_addr_out, 7'h55 ^ 7'(i - 1));
			end
			start_in = i < 4;
			op_in = i[0] ? return_rotate_pkg::OP_ROTATE_RIGHT_CARRY : return_rotate_pkg::OP_ROTATE_LEFT_CARRY;
			dest_in = i[1];
			file_addr_in = 7'h55 ^ 7'(i);
			file_data_in = 8'hE6 ^ 8'(i);
			carry_in = i[1];
			e = i[0] ? {file_data_in[0], carry_in, file_data_in[7:1]} : {file_data_in, carry_in};
			pd = dest_in;
		end
	endtask : t_rotate
	// a rotate requested during busy must be refused
	task t_return(input return_rotate_pkg::op_e o, input logic [7:0] k, input logic [14:0] top);
		logic lit;
		logic rfi;
		lit = o == return_rotate_pkg::OP_RETURN_LOADING_LITERAL;
		rfi = o == return_rotate_pkg::OP_RETURN_FROM_INTERRUPT;
		@(posedge clk_in);
		#1;
		start_in = 1;
		op_in = o;
		literal_in = k;
		stack_top_in = ~top;
		@(posedge clk_in);
		#1;
		chk({busy_out, done_out}, 2'b10);
		op_in = return_rotate_pkg::OP_ROTATE_LEFT_CARRY;
		stack_top_in = top;
		@(posedge clk_in);
		#1;
		start_in = 0;
		chk({done_out, stack_pop_out, pc_load_out, carry_we_out}, 4'hE);
		chk(pc_out, top);
		chk({acc_we_out, irq_enable_set_out, irq_enable_mask_out}, {lit, rfi, rfi, 7'h00});
		if (lit) chk(acc_out, k);
	endtask : t_return
	initial begin
		repeat (10) @(posedge clk_in);
		#1 rst_n_in = 1;
		t_rotate();
		t_return(return_rotate_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 15'h7FFF);
		t_return(return_rotate_pkg::OP_RETURN_SUB, 8'hFF, 15'h1234);
		t_return(return_rotate_pkg::OP_RETURN_LOADING_LITERAL, 8'hFF, 15'h0001);
		final_report();
	end
endmodule : tb
`default_nettype wire
